// ===== shared/mstl_pkg.sv
package mstl_pkg;
  // ==========================================
  // refresh address counter
  localparam logic [7:0] REFRESH_COUNT_TOP = 8'hff;
  localparam logic [7:0] REFRESH_COUNT_RESET = 8'h00;
  // load clock divider: one load clock period in system clocks
  localparam int LOAD_CLOCK_DIV = 4;
  localparam logic [3:0] LOAD_DIV_LAST = 4'(LOAD_CLOCK_DIV - 1);
  localparam logic [3:0] LOAD_DIV_RESET = 4'h0;
  // ==========================================
  // bus cycle kinds and states
  typedef enum logic [2:0] {
    MSTL_IDLE = 3'b001,
    MSTL_BUS = 3'b010,
    MSTL_REFRESH = 3'b100
  } mstl_state_t;
endpackage

// ===== rtl/mstl_refresh_counter.sv
`timescale 1ns/100ps
module mstl_refresh_counter (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic load_tick,
  input wire logic blank_n,
  input wire logic line_end,
  output logic at_top,
  output logic [7:0] count
);
  // ==========================================
  // address counter, held cleared while blanked
  logic [7:0] count_reg;
  logic [7:0] count_next;
  logic top_reg;
  logic top_next;

  always_comb begin
    count_next = count_reg;
    top_next = 1'b0;
    if (load_tick) begin
      if (!blank_n) begin
        count_next = mstl_pkg::REFRESH_COUNT_RESET;
      end else begin
        count_next = count_reg + 8'h01;
      end
      // flag top one load period after reaching the top, or at line end
      top_next = (count_reg == mstl_pkg::REFRESH_COUNT_TOP) || line_end;
    end else begin
      top_next = top_reg;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      count_reg <= mstl_pkg::REFRESH_COUNT_RESET;
      top_reg <= 1'b0;
    end else begin
      count_reg <= count_next;
      top_reg <= top_next;
    end
  end

  assign at_top = top_reg;
  assign count = count_reg;
endmodule

// ===== rtl/mstl_refresh_ctrl.sv
`timescale 1ns/100ps
// Notes on behaviour
// - the refresh address counter steps each load clock while unblanked and a request rises at 255 or line end.
// - while the request stands the refresh cycle is the next bus cycle after the current one.
// - the internal request rises exactly two load periods after the counter reaches 255.
// - a bus cycle in progress is held until wait is sampled high, then refresh begins if a request stands, else idle.
module mstl_refresh_ctrl (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic blank_n,
  input wire logic line_end,
  input wire logic bus_request,
  input wire logic wait_in,
  output logic load_clock,
  output logic refresh_request_low,
  output logic refresh_cycle,
  output logic bus_cycle,
  output logic reset_out_n,
  output logic [7:0] refresh_address
);
  // ==========================================
  // load clock generation
  logic [3:0] div_reg;
  logic [3:0] div_next;
  logic lck_reg;
  logic lck_next;
  logic load_tick;

  always_comb begin
    div_next = div_reg + 4'h1;
    if (div_reg == mstl_pkg::LOAD_DIV_LAST) begin
      div_next = mstl_pkg::LOAD_DIV_RESET;
    end
    lck_next = (div_next < 4'(mstl_pkg::LOAD_CLOCK_DIV / 2));
  end

  assign load_tick = (div_reg == mstl_pkg::LOAD_DIV_LAST);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      div_reg <= mstl_pkg::LOAD_DIV_RESET;
      lck_reg <= 1'b1;
    end else begin
      div_reg <= div_next;
      lck_reg <= lck_next;
    end
  end

  // ==========================================
  // refresh address counter
  logic at_top;
  logic [7:0] count;

  mstl_refresh_counter u_counter (
    .sys_clk(sys_clk),
    .rst(rst),
    .load_tick(load_tick),
    .blank_n(blank_n),
    .line_end(line_end),
    .at_top(at_top),
    .count(count)
  );

  // ==========================================
  // request and bus cycle sequencing
  mstl_pkg::mstl_state_t state_reg;
  mstl_pkg::mstl_state_t state_next;
  logic req_reg;
  logic req_next;
  logic [7:0] addr_reg;
  logic [7:0] addr_next;

  always_comb begin
    state_next = state_reg;
    req_next = req_reg;
    addr_next = count;
    if (at_top && load_tick) begin
      req_next = 1'b1;
    end
    unique case (state_reg)
      mstl_pkg::MSTL_IDLE: begin
        if (req_reg) begin
          state_next = mstl_pkg::MSTL_REFRESH;
        end else if (bus_request) begin
          state_next = mstl_pkg::MSTL_BUS;
        end
      end
      mstl_pkg::MSTL_BUS: begin
        // any length: only wait high ends it
        if (wait_in) begin
          state_next = req_reg ? mstl_pkg::MSTL_REFRESH : mstl_pkg::MSTL_IDLE;
        end
      end
      mstl_pkg::MSTL_REFRESH: begin
        // wait states come from the outside bus state machine
        if (wait_in) begin
          state_next = mstl_pkg::MSTL_IDLE;
          req_next = at_top && load_tick;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_reg <= mstl_pkg::MSTL_IDLE;
      req_reg <= 1'b0;
      addr_reg <= mstl_pkg::REFRESH_COUNT_RESET;
    end else begin
      state_reg <= state_next;
      req_reg <= req_next;
      addr_reg <= addr_next;
    end
  end

  // ==========================================
  // registered outputs
  // request pin gets its own flop so no inverter sits behind the output
  logic refresh_reg;
  logic bus_reg;
  logic rstn_reg;
  logic req_low_reg;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      refresh_reg <= 1'b0;
      bus_reg <= 1'b0;
      rstn_reg <= 1'b0;
      req_low_reg <= 1'b1;
    end else begin
      refresh_reg <= (state_next == mstl_pkg::MSTL_REFRESH);
      bus_reg <= (state_next == mstl_pkg::MSTL_BUS);
      rstn_reg <= 1'b1;
      req_low_reg <= ~req_next;
    end
  end

  assign load_clock = lck_reg;
  assign refresh_request_low = req_low_reg;
  assign refresh_cycle = refresh_reg;
  assign bus_cycle = bus_reg;
  assign reset_out_n = rstn_reg;
  assign refresh_address = addr_reg;

  // ==========================================
  // checks
  a_req_after_top: assert property (@(posedge sys_clk) disable iff (rst)
    (at_top && load_tick) |=> !refresh_request_low)
    else $error("request missing after count top");
  a_bus_held: assert property (@(posedge sys_clk) disable iff (rst)
    (state_reg == mstl_pkg::MSTL_BUS && !wait_in) |=> state_reg == mstl_pkg::MSTL_BUS)
    else $error("bus cycle ended without wait high");
  a_refresh_next: assert property (@(posedge sys_clk) disable iff (rst)
    (state_reg == mstl_pkg::MSTL_BUS && wait_in && req_reg)
    |=> state_reg == mstl_pkg::MSTL_REFRESH)
    else $error("refresh not next after bus cycle");
  a_req_holds: assert property (@(posedge sys_clk) disable iff (rst)
    (req_reg && state_reg != mstl_pkg::MSTL_REFRESH) |=> req_reg)
    else $error("request dropped before refresh");
  a_refresh_waits: assert property (@(posedge sys_clk) disable iff (rst)
    (state_reg == mstl_pkg::MSTL_REFRESH && !wait_in) |=> refresh_cycle)
    else $error("refresh ended during wait states");
  a_addr_steps: assert property (@(posedge sys_clk) disable iff (rst)
    (load_tick && blank_n) |=> count == $past(count) + 8'h01)
    else $error("address counter did not step");
  a_out_state: assert property (@(posedge sys_clk) disable iff (rst)
    !(refresh_cycle && bus_cycle))
    else $error("bus and refresh cycle together");
  a_tick_period: assert property (@(posedge sys_clk) disable iff (rst)
    load_tick |=> !load_tick [*3] ##1 load_tick)
    else $error("load period wrong");

  // ==========================================
  // request source and release
  a_req_source: assert property (@(posedge sys_clk) disable iff (rst)
    (!req_reg ##1 req_reg) |-> $past(at_top) && $past(load_tick))
    else $error("request rose without count top");
  a_line_end_top: assert property (@(posedge sys_clk) disable iff (rst)
    (line_end && load_tick) |=> at_top)
    else $error("line end did not raise top");
  a_refresh_clears: assert property (@(posedge sys_clk) disable iff (rst)
    (state_reg == mstl_pkg::MSTL_REFRESH && wait_in && !load_tick)
    |=> !req_reg && !refresh_cycle)
    else $error("refresh did not release");
  a_idle_priority: assert property (@(posedge sys_clk) disable iff (rst)
    (state_reg == mstl_pkg::MSTL_IDLE && req_reg) |=> state_reg == mstl_pkg::MSTL_REFRESH)
    else $error("pending request not served next");
  a_refused_bus: assert property (@(posedge sys_clk) disable iff (rst)
    (state_reg == mstl_pkg::MSTL_IDLE && req_reg && bus_request) |=> !bus_cycle)
    else $error("bus cycle taken over pending refresh");

  // ==========================================
  // scenario covers
  c_refresh_run: cover property (@(posedge sys_clk) disable iff (rst)
    state_reg == mstl_pkg::MSTL_REFRESH);
  c_bus_then_refresh: cover property (@(posedge sys_clk) disable iff (rst)
    state_reg == mstl_pkg::MSTL_BUS ##1 state_reg == mstl_pkg::MSTL_REFRESH);
  c_line_end_req: cover property (@(posedge sys_clk) disable iff (rst)
    line_end && load_tick ##1 req_reg);
  c_bus_plain: cover property (@(posedge sys_clk) disable iff (rst)
    state_reg == mstl_pkg::MSTL_BUS ##1 state_reg == mstl_pkg::MSTL_IDLE);
endmodule

// ===== tb/mstl_bus_model.sv
`timescale 1ns/100ps
// ==========================================
// helper circuit and bus state machine at the far side
module mstl_bus_model #(
  parameter int N = 2
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic load_clock,
  input wire logic blank_n,
  input wire logic refresh_request_low,
  input wire logic refresh_cycle,
  input wire logic bus_cycle,
  input wire logic [3:0] bus_len,
  output logic delayed_blank_n,
  output logic transfer_output_enable_low,
  output logic wait_in
);
  logic [1:0] down_reg;
  logic [3:0] len_reg;
  logic lck_reg;
  logic latch_low_reg;
  logic [1:0] blank_reg;
  logic lck_rise;
  logic finish;
  assign lck_rise = load_clock && !lck_reg;
  // finish only once the countdown has run out
  assign finish = refresh_cycle && down_reg == 2'h0;
  always_ff @(posedge sys_clk) begin
    lck_reg <= load_clock;
    if (rst || finish) begin
      latch_low_reg <= 1'b1;
    end else if (!refresh_request_low) begin
      latch_low_reg <= 1'b0;
    end
    if (rst || latch_low_reg) begin
      down_reg <= 2'(N);
    end else if (lck_rise && down_reg != 2'h0) begin
      down_reg <= down_reg - 2'h1;
    end
    if (rst) begin
      blank_reg <= 2'h0;
    end else if (lck_rise) begin
      blank_reg <= {blank_reg[0], blank_n};
    end
    len_reg <= bus_cycle ? len_reg + 4'h1 : 4'h0;
  end
  assign delayed_blank_n = blank_reg[1];
  assign transfer_output_enable_low = !(refresh_cycle && !finish);
  // fixed countdown keeps request-to-finish constant unless a bus cycle runs past its end
  assign wait_in = finish || (bus_cycle && len_reg >= bus_len);
endmodule

// ===== tb/testbench.sv
`timescale 1ns/100ps
module testbench;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic blank_n = 1'b0;
  logic line_end = 1'b0;
  logic bus_request = 1'b0;
  logic [3:0] bus_len = 4'hf;
  logic wait_in, load_clock, refresh_request_low, refresh_cycle, bus_cycle;
  logic reset_out_n, delayed_blank_n, transfer_output_enable_low;
  logic [7:0] refresh_address;
  int bad_count = 0;
  int tests_run = 0;
  int n;
  int gap_top;
  localparam int D = mstl_pkg::LOAD_CLOCK_DIV;
  always #5 sys_clk = ~sys_clk;
  mstl_refresh_ctrl uut (
    .sys_clk(sys_clk),
    .rst(rst),
    .blank_n(delayed_blank_n),
    .line_end(line_end),
    .bus_request(bus_request),
    .wait_in(wait_in),
    .load_clock(load_clock),
    .refresh_request_low(refresh_request_low),
    .refresh_cycle(refresh_cycle),
    .bus_cycle(bus_cycle),
    .reset_out_n(reset_out_n),
    .refresh_address(refresh_address)
  );
  // countdown of two matches the two-stage blanking delay; covers a 16-cycle bus cycle
  mstl_bus_model #(.N(2)) bus (
    .sys_clk(sys_clk),
    .rst(rst),
    .load_clock(load_clock),
    .blank_n(blank_n),
    .refresh_request_low(refresh_request_low),
    .refresh_cycle(refresh_cycle),
    .bus_cycle(bus_cycle),
    .bus_len(bus_len),
    .delayed_blank_n(delayed_blank_n),
    .transfer_output_enable_low(transfer_output_enable_low),
    .wait_in(wait_in)
  );
  // ==========================================
  // checks and waits
  task automatic check(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t got %b want %b", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic step();
    @(posedge sys_clk);
    n++;
    if (n > 3000) begin
      bad_count++;
      $display("ERROR %0t wait ran out", $time);
      finish_test();
    end
  endtask
  // ==========================================
  // scenarios
  task automatic test_top();
    int h;
    h = 0;
    n = 0;
    repeat (D) begin
      step();
      h += load_clock;
    end
    check(h == D / 2, 1'b1);
    n = 0;
    while (refresh_address !== 8'hff) step();
    check(refresh_request_low, 1'b1);
    n = 0;
    while (refresh_request_low !== 1'b0) step();
    check(n >= D - 1 && n <= 2 * D + 1, 1'b1);
    n = 0;
    while (refresh_cycle !== 1'b1) step();
    check(n <= 2, 1'b1);
    check(transfer_output_enable_low, 1'b0);
    while (refresh_request_low !== 1'b1) step();
    gap_top = n;
    check(n >= 2 * D && n <= 4 * D + 2, 1'b1);
    check(refresh_cycle, 1'b0);
    check(transfer_output_enable_low, 1'b1);
    $display("test top done");
  endtask
  task automatic test_line();
    blank_n <= 1'b0;
    repeat (2 * D) @(posedge sys_clk);
    blank_n <= 1'b1;
    line_end <= 1'b1;
    repeat (D) @(posedge sys_clk);
    line_end <= 1'b0;
    n = 0;
    while (refresh_request_low !== 1'b0) step();
    check(n <= 2 * D, 1'b1);
    check(refresh_address < 8'h10, 1'b1);
    n = 0;
    while (refresh_request_low !== 1'b1) step();
    check(n == gap_top, 1'b1);
    $display("test line done");
  endtask
  task automatic test_bus();
    int m;
    n = 0;
    while (refresh_address !== 8'hfe) step();
    bus_request <= 1'b1;
    n = 0;
    while (bus_cycle !== 1'b1) step();
    bus_request <= 1'b0;
    n = 0;
    while (refresh_request_low !== 1'b0) step();
    check(bus_cycle, 1'b1);
    check(refresh_cycle, 1'b0);
    n = 0;
    while (bus_cycle !== 1'b0) step();
    m = n;
    while (refresh_cycle !== 1'b1) step();
    check(n - m <= 2, 1'b1);
    while (refresh_request_low !== 1'b1) step();
    check(n == gap_top, 1'b1);
    $display("test bus done");
  endtask
  initial begin
    repeat (16) @(posedge sys_clk);
    check(reset_out_n, 1'b0);
    check(refresh_request_low, 1'b1);
    rst <= 1'b0;
    blank_n <= 1'b1;
    repeat (2) @(posedge sys_clk);
    check(reset_out_n, 1'b1);
    test_top();
    test_line();
    test_bus();
    finish_test();
  end
endmodule
